// file: logic/wit_pkg.sv
/*
  Constants for the low-speed guard: register offsets, field positions,
  reset values, key codes, interval terminals and power-mode codes.
  Assumes a 32-bit AXI4-Lite slave with byte addresses in the low 8 bits.
*/
package wit_pkg;

  localparam int CNT_W = 15;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_IRQEN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // guard_control fields
  localparam int CTL_CLR_HI = 7;
  localparam int CTL_CLR_LO = 4;
  localparam int CTL_EN = 3;
  localparam int CTL_MODE = 2;
  localparam int CTL_INT_HI = 1;
  localparam int CTL_INT_LO = 0;

  // single-bit fields of flag, irq enable and status registers
  localparam int FLAG_BIT = 0;
  localparam int IRQEN_BIT = 0;
  localparam int ST_COUNTING = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_PENDING = 2;

  localparam logic [3:0] CLR_RESET = 4'h0;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [3:0] KEY_FIRST = 4'ha;
  localparam logic [3:0] KEY_SECOND = 4'h5;
  localparam logic MODE_WATCHDOG = 1'b0;
  localparam logic MODE_TIMER = 1'b1;

  // interval select codes and period counts
  localparam logic [1:0] SEL_32768 = 2'h0;
  localparam logic [1:0] SEL_8192 = 2'h1;
  localparam logic [1:0] SEL_512 = 2'h2;
  localparam logic [1:0] SEL_64 = 2'h3;
  localparam int PER_32768 = 32768;
  localparam int PER_8192 = 8192;
  localparam int PER_512 = 512;
  localparam int PER_64 = 64;
  localparam logic [CNT_W-1:0] TERM_32768 = CNT_W'(PER_32768 - 1);
  localparam logic [CNT_W-1:0] TERM_8192 = CNT_W'(PER_8192 - 1);
  localparam logic [CNT_W-1:0] TERM_512 = CNT_W'(PER_512 - 1);
  localparam logic [CNT_W-1:0] TERM_64 = CNT_W'(PER_64 - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;

  // power mode codes on the powerMode input
  localparam logic [2:0] PM_ACTIVE = 3'h0;
  localparam logic [2:0] PM_ZERO = 3'h1;
  localparam logic [2:0] PM_ONE = 3'h2;
  localparam logic [2:0] PM_TWO = 3'h3;
  localparam logic [2:0] PM_THREE = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: logic/wit_guard.sv
/*
  Low-speed guard: watchdog or interval timer on a 15-bit counter that
  advances on rising edges of the low-speed oscillator, with an AXI4-Lite
  register slave. Assumes lowSpeedClk is a free-running slow square wave,
  far slower than clock, and powerMode is driven by the power manager.
*/
// Operation
// - 15-bit counter advances on low-speed oscillator edges; software cannot access it.
// - entering power_mode_two or power_mode_three forces the counter to zero.
// - after reset the counter is disabled and idle in both modes.
// - mode bit 0 gives watchdog; counting starts when enable is written 1.
// - in running watchdog mode, writing enable 0 is ignored.
// - timeout is 64, 512, 8192 or 32768 low-speed periods by interval_select.
// - select 00 is 32768, 01 is 8192, 10 is 512, 11 is 64.
// - watchdog timeout asserts the system reset output.
// - key 1010 then 0101 within half a slow period zeroes the counter.
// - a timeout tick between the two keys disarms the first key; the reset is still requested.
// - running watchdog ignores mode writes but accepts interval_select changes.
// - watchdog mode never raises an interrupt request.
// - mode bit 1 gives interval timer, started by writing enable 1.
// - timer expiry sets guard_irq_flag; interrupt requested only when guard_irq_enable is 1.
// - in timer mode writing 1 to clear_key_field bit 0 zeroes the counter.
// - in timer mode enable 0 stops counting; enable 1 restarts from zero.
// - timer mode never asserts the system reset.
// - active mode and power_mode_zero keep counting and reset on timeout.
// - power_mode_one counts without reset; expiry then resets on return to active.
// - power_mode_two/three stop and zero counter, keep configuration, restart afterward.
// - with enable 0, clear_key_field writes leave the counter alone.
module wit_guard (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       lowSpeedClk,
  input  wire logic [2:0]                 powerMode,
  input  wire logic [wit_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [wit_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            sysResetReq,
  output logic                            guardIrqReq
);

  // slow clock synchronizer and edge detection
  logic                       lsSync1_q;
  logic                       lsSync2_q;
  logic                       lsSync3_q;
  logic                       slowTick;
  logic                       slowToggle;

  // guard_control and companion registers
  logic [3:0]                 clrKey_q;
  logic                       enable_q;
  logic                       mode_q;
  logic [1:0]                 intSel_q;
  logic                       irqFlag_q;
  logic                       irqEnable_q;
  logic                       armed_q;
  logic                       pending_q;
  logic                       resetReq_q;
  logic                       irqOut_q;
  logic [wit_pkg::CNT_W-1:0]  count_q;

  logic                       enable_d;
  logic                       mode_d;
  logic                       armed_d;
  logic                       pending_d;
  logic                       irqFlag_d;
  logic                       irqEnable_d;
  logic [wit_pkg::CNT_W-1:0]  count_d;

  // bus slave state
  logic                       awReady_q;
  logic                       wReady_q;
  logic                       awHeld_q;
  logic                       wHeld_q;
  logic [wit_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0]                wData_q;
  logic [3:0]                 wStrb_q;
  logic                       bValid_q;
  logic [1:0]                 bResp_q;
  logic                       arReady_q;
  logic                       rValid_q;
  logic [31:0]                rData_q;
  logic [1:0]                 rResp_q;

  logic                       awTake;
  logic                       wTake;
  logic                       arTake;
  logic                       bDone;
  logic                       rDone;
  logic                       wrFire;
  logic                       awHeldNext;
  logic                       wHeldNext;
  logic                       wrMapped;
  logic                       rdMapped;
  logic                       lane0;
  logic [7:0]                 wByte;
  logic                       wrCtl;
  logic                       wrFlag;
  logic                       wrIrqEn;
  logic [31:0]                rdWord;

  // decoded control write
  logic [3:0]                 newClr;
  logic                       newEn;
  logic                       newMode;
  logic                       ctlLocked;
  logic                       isWatchdog;
  logic                       startZero;
  logic                       clrActive;
  logic                       keyFirst;
  logic                       keySecond;
  logic                       timerClr;

  // counting and power mode
  logic                       pmRun;
  logic                       pmHold;
  logic                       pmResetOk;
  logic                       counting;
  logic                       cntZero;
  logic [wit_pkg::CNT_W-1:0]  termSel;
  logic                       atTerm;
  logic                       expire;
  logic                       wdExpire;
  logic                       tmExpire;
  logic                       resetNow;
  logic                       flagClr;

  // ---------------- slow clock crossing ----------------
  always_ff @(posedge clock) begin
    lsSync1_q <= lowSpeedClk;
    lsSync2_q <= lsSync1_q;
    lsSync3_q <= lsSync2_q;
  end

  assign slowTick = lsSync2_q & ~lsSync3_q;
  assign slowToggle = lsSync2_q ^ lsSync3_q;

  // ---------------- bus handshakes ----------------
  assign awTake = s_axi_awvalid & awReady_q;
  assign wTake = s_axi_wvalid & wReady_q;
  assign arTake = s_axi_arvalid & arReady_q;
  assign bDone = bValid_q & s_axi_bready;
  assign rDone = rValid_q & s_axi_rready;
  assign wrFire = awHeld_q & wHeld_q & ~bValid_q;
  assign awHeldNext = wrFire ? 1'b0 : (awTake | awHeld_q);
  assign wHeldNext = wrFire ? 1'b0 : (wTake | wHeld_q);

  assign wrMapped = (awAddr_q == wit_pkg::OFS_CONTROL) |
                    (awAddr_q == wit_pkg::OFS_FLAG) |
                    (awAddr_q == wit_pkg::OFS_IRQEN) |
                    (awAddr_q == wit_pkg::OFS_STATUS);
  assign rdMapped = (s_axi_araddr == wit_pkg::OFS_CONTROL) |
                    (s_axi_araddr == wit_pkg::OFS_FLAG) |
                    (s_axi_araddr == wit_pkg::OFS_IRQEN) |
                    (s_axi_araddr == wit_pkg::OFS_STATUS);
  assign lane0 = wrFire & wStrb_q[0];
  assign wByte = wData_q[7:0];
  assign wrCtl = lane0 & (awAddr_q == wit_pkg::OFS_CONTROL);
  assign wrFlag = lane0 & (awAddr_q == wit_pkg::OFS_FLAG);
  assign wrIrqEn = lane0 & (awAddr_q == wit_pkg::OFS_IRQEN);

  always_ff @(posedge clock) begin
    if (rst) begin
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= wit_pkg::RESP_OKAY;
    end else begin
      awReady_q <= ~awHeldNext;
      wReady_q <= ~wHeldNext;
      awHeld_q <= awHeldNext;
      wHeld_q <= wHeldNext;
      if (wrFire) begin
        bValid_q <= 1'b1;
        bResp_q <= wrMapped ? wit_pkg::RESP_OKAY : wit_pkg::RESP_SLVERR;
      end else if (bDone) begin
        bValid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  // read data: the counter itself is never visible
  always_comb begin
    rdWord = '0;
    case (s_axi_araddr)
      wit_pkg::OFS_CONTROL: begin
        rdWord[wit_pkg::CTL_CLR_HI:wit_pkg::CTL_CLR_LO] = clrKey_q;
        rdWord[wit_pkg::CTL_EN] = enable_q;
        rdWord[wit_pkg::CTL_MODE] = mode_q;
        rdWord[wit_pkg::CTL_INT_HI:wit_pkg::CTL_INT_LO] = intSel_q;
      end
      wit_pkg::OFS_FLAG: begin
        rdWord[wit_pkg::FLAG_BIT] = irqFlag_q;
      end
      wit_pkg::OFS_IRQEN: begin
        rdWord[wit_pkg::IRQEN_BIT] = irqEnable_q;
      end
      wit_pkg::OFS_STATUS: begin
        rdWord[wit_pkg::ST_COUNTING] = counting;
        rdWord[wit_pkg::ST_ARMED] = armed_q;
        rdWord[wit_pkg::ST_PENDING] = pending_q;
      end
      default: begin
        rdWord = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= wit_pkg::RESP_OKAY;
    end else if (arTake) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= rdWord;
      rResp_q <= rdMapped ? wit_pkg::RESP_OKAY : wit_pkg::RESP_SLVERR;
    end else if (rDone) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
    end else begin
      arReady_q <= ~rValid_q;
    end
  end

  // ---------------- control write decode ----------------
  assign newClr = wByte[wit_pkg::CTL_CLR_HI:wit_pkg::CTL_CLR_LO];
  assign newEn = wByte[wit_pkg::CTL_EN];
  assign newMode = wByte[wit_pkg::CTL_MODE];
  assign isWatchdog = (mode_q == wit_pkg::MODE_WATCHDOG);
  assign ctlLocked = enable_q & isWatchdog;

  assign mode_d = (wrCtl & ~ctlLocked) ? newMode : mode_q;
  assign enable_d = ~wrCtl ? enable_q :
                    ctlLocked ? 1'b1 :
                    newEn;
  // start or timer restart zeroes the count; a locked watchdog is not restarted
  assign startZero = wrCtl & newEn & ~ctlLocked;

  assign clrActive = wrCtl & enable_q;
  assign keyFirst = clrActive & isWatchdog & (newClr == wit_pkg::KEY_FIRST);
  assign keySecond = clrActive & isWatchdog & armed_q &
                     (newClr == wit_pkg::KEY_SECOND);
  assign timerClr = clrActive & ~isWatchdog & newClr[0];

  // first key stays armed until another control write or the next slow edge, i.e. half a slow period
  assign armed_d = keyFirst ? 1'b1 :
                   (clrActive & isWatchdog) ? 1'b0 :
                   (slowToggle | ~enable_q) ? 1'b0 :
                   armed_q;

  // ---------------- counter and timeout ----------------
  assign pmRun = (powerMode == wit_pkg::PM_ACTIVE) |
                 (powerMode == wit_pkg::PM_ZERO) |
                 (powerMode == wit_pkg::PM_ONE);
  assign pmHold = (powerMode == wit_pkg::PM_TWO) |
                  (powerMode == wit_pkg::PM_THREE);
  assign pmResetOk = (powerMode == wit_pkg::PM_ACTIVE) |
                     (powerMode == wit_pkg::PM_ZERO);

  assign counting = enable_q & pmRun;
  assign cntZero = pmHold | startZero | keySecond | timerClr;

  assign termSel = (intSel_q == wit_pkg::SEL_32768) ? wit_pkg::TERM_32768 :
                   (intSel_q == wit_pkg::SEL_8192) ? wit_pkg::TERM_8192 :
                   (intSel_q == wit_pkg::SEL_512) ? wit_pkg::TERM_512 :
                   wit_pkg::TERM_64;
  assign atTerm = (count_q == termSel);
  assign expire = counting & slowTick & atTerm & ~cntZero;
  assign wdExpire = expire & isWatchdog;
  assign tmExpire = expire & ~isWatchdog;

  assign count_d = cntZero ? wit_pkg::CNT_ZERO :
                   ~(counting & slowTick) ? count_q :
                   atTerm ? wit_pkg::CNT_ZERO :
                   count_q + 1'b1;

  // expiry in power_mode_one waits for a mode that may reset the chip
  assign pending_d = (pmHold | keySecond | ~enable_q) ? 1'b0 :
                     (wdExpire & (powerMode == wit_pkg::PM_ONE)) ? 1'b1 :
                     pending_q;
  assign resetNow = isWatchdog & pmResetOk &
                    (wdExpire | (pending_q & enable_q));

  // a timer expiry in the same cycle as a software clear keeps the flag
  assign flagClr = wrFlag & wByte[wit_pkg::FLAG_BIT];
  assign irqFlag_d = tmExpire | (irqFlag_q & ~flagClr);
  assign irqEnable_d = wrIrqEn ? wByte[wit_pkg::IRQEN_BIT] : irqEnable_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      clrKey_q <= wit_pkg::CLR_RESET;
      enable_q <= 1'b0;
      mode_q <= wit_pkg::MODE_WATCHDOG;
      intSel_q <= wit_pkg::INT_RESET;
    end else begin
      if (wrCtl) begin
        clrKey_q <= newClr;
        intSel_q <= wByte[wit_pkg::CTL_INT_HI:wit_pkg::CTL_INT_LO];
      end
      enable_q <= enable_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= wit_pkg::CNT_ZERO;
      armed_q <= 1'b0;
      pending_q <= 1'b0;
      irqFlag_q <= 1'b0;
      irqEnable_q <= 1'b0;
    end else begin
      count_q <= count_d;
      armed_q <= armed_d;
      pending_q <= pending_d;
      irqFlag_q <= irqFlag_d;
      irqEnable_q <= irqEnable_d;
    end
  end

  // reset request holds until the system reset comes back to this block
  always_ff @(posedge clock) begin
    if (rst) begin
      resetReq_q <= 1'b0;
      irqOut_q <= 1'b0;
    end else begin
      resetReq_q <= resetReq_q | resetNow;
      irqOut_q <= irqFlag_d & irqEnable_d;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign sysResetReq = resetReq_q;
  assign guardIrqReq = irqOut_q;

endmodule // wit_guard

// file: verification/wit_guard_assertions.sv
/*
  Port-level checker for the low-speed guard: bus handshakes and the
  reset and interrupt outputs. Bound to wit_guard from the bench top file.
*/
module wit_guard_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sysResetReq,
  input wire logic        guardIrqReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wrAnswer;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_writeAnswer; s_wrTaken |-> s_wrAnswer; endproperty
  a_writeAnswer: assert property (p_writeAnswer) else $error("write response late or early");
  property p_readAnswer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_readAnswer: assert property (p_readAnswer) else $error("read data not one cycle after address");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped before taken");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped before taken");
  property p_readyBack; s_axi_bvalid && s_axi_bready |-> ##[0:2] s_axi_awready; endproperty
  a_readyBack: assert property (p_readyBack) else $error("write address not ready again");
  property p_errData;
    s_axi_rvalid && s_axi_rresp == wit_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_errData: assert property (p_errData) else $error("error read returns data");
  property p_upperZero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper read bits not zero");
  property p_resetSticky; sysResetReq |=> sysResetReq; endproperty
  a_resetSticky: assert property (p_resetSticky) else $error("system reset request dropped");
  property p_resetClean; $fell(rst) |-> !sysResetReq && !guardIrqReq; endproperty
  a_resetClean: assert property (p_resetClean) else $error("outputs active after reset");
  property p_irqFall; $fell(guardIrqReq) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_irqFall: assert property (p_irqFall) else $error("interrupt dropped without a write");
endmodule // wit_guard_assertions

// file: verification/wit_guard_tb.sv
/*
  Self-checking bench for wit_guard: AXI4-Lite master tasks, a slow clock
  made from the system clock, and queued bus expectations.
  Assumes the design and its package compile before this file.
*/
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module wit_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic        lowSpeedClk = 1'h0;
  logic [2:0]  powerMode = wit_pkg::PM_ACTIVE;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sysResetReq, guardIrqReq;
  int          miscompares = 0, n_tests = 0, edgeCnt = 0, markCnt = 0, halfPer = 20, slowDiv = 0;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [33:0] note;
  logic [1:0]  bnote;
  logic [1:0]  codes[3] = '{2'h3, 2'h2, 2'h1};
  int          pers[3] = '{64, 512, 8192};
  logic [7:0]  ofs[4] = '{wit_pkg::OFS_CONTROL, wit_pkg::OFS_FLAG, wit_pkg::OFS_IRQEN,
                          wit_pkg::OFS_STATUS};

  wit_guard u_wit_guard (.clock(clock), .rst(rst), .lowSpeedClk(lowSpeedClk),
    .powerMode(powerMode), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sysResetReq(sysResetReq),
    .guardIrqReq(guardIrqReq));

  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (slowDiv >= halfPer - 1) begin
      slowDiv <= 0;
      lowSpeedClk <= ~lowSpeedClk;
    end else begin
      slowDiv <= slowDiv + 1;
    end
  end
  always @(posedge lowSpeedClk) edgeCnt <= edgeCnt + 1;

  // scoreboard: oldest note against each response handshake
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) begin
      bnote = bq.pop_front();
      `CHK("bresp", bnote, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      note = rq.pop_front();
      `CHK("rresp_rdata", note, {s_axi_rresp, s_axi_rdata})
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bready stands from the request until bvalid is sampled high
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = wit_pkg::RESP_OKAY);
    bq.push_back(er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($urandom());
    s_axi_wdata <= {24'($urandom()), d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = wit_pkg::RESP_OKAY);
    rq.push_back({er, 24'h0, d});
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($urandom());
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  task automatic pins(input logic r, input logic i);
    `CHK("sysResetReq", r, sysResetReq)
    `CHK("guardIrqReq", i, guardIrqReq)
  endtask

  // mark sits mid slow period so a write lands before the next tick
  task automatic mark;
    @(negedge lowSpeedClk);
    markCnt = edgeCnt;
  endtask

  task automatic upto(input int n);
    while (edgeCnt < markCnt + n) @(edgeCnt);
    repeat (6) @(negedge clock);
  endtask

  task automatic doReset;
    @(posedge clock);
    rst <= 1'h1;
    powerMode <= wit_pkg::PM_ACTIVE;
    repeat (6) @(posedge clock);
    rst <= 1'h0;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hb05e));
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    wr(wit_pkg::OFS_STATUS, 8'hff);
    wr(8'h10, 8'hff, wit_pkg::RESP_SLVERR);
    for (int k = 0; k < 4; k++) rd(ofs[k], 8'h00);
    rd(8'h10, 8'h00, wit_pkg::RESP_SLVERR);
    wr(wit_pkg::OFS_IRQEN, 8'h01);
    rd(wit_pkg::OFS_IRQEN, 8'h01);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h0a);
    wr(wit_pkg::OFS_CONTROL, 8'h07);
    rd(wit_pkg::OFS_CONTROL, 8'h0b);
    rd(wit_pkg::OFS_STATUS, 8'h01);
    upto(40);
    pins(1'h0, 1'h0);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'hab);
    wr(wit_pkg::OFS_CONTROL, 8'h5b);
    upto(30);
    wr(wit_pkg::OFS_CONTROL, 8'hab);
    wr(wit_pkg::OFS_CONTROL, 8'h0b);
    wr(wit_pkg::OFS_CONTROL, 8'h5b);
    wr(wit_pkg::OFS_CONTROL, 8'hab);
    upto(31);
    @(negedge lowSpeedClk);
    wr(wit_pkg::OFS_CONTROL, 8'h5b);
    upto(63);
    pins(1'h0, 1'h0);
    upto(64);
    pins(1'h1, 1'h0);
    doReset();
    halfPer = 10;
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h0b);
    powerMode <= wit_pkg::PM_ONE;
    upto(66);
    pins(1'h0, 1'h0);
    rd(wit_pkg::OFS_STATUS, 8'h05);
    @(posedge clock);
    powerMode <= wit_pkg::PM_ACTIVE;
    repeat (3) @(negedge clock);
    pins(1'h1, 1'h0);
    for (int k = 0; k < 2; k++) begin
      doReset();
      mark();
      wr(wit_pkg::OFS_CONTROL, 8'h0b);
      upto(40);
      @(posedge clock);
      powerMode <= (k == 0) ? wit_pkg::PM_TWO : wit_pkg::PM_THREE;
      upto(50);
      pins(1'h0, 1'h0);
      rd(wit_pkg::OFS_CONTROL, 8'h0b);
      mark();
      @(posedge clock);
      powerMode <= (k == 0) ? wit_pkg::PM_ACTIVE : wit_pkg::PM_ZERO;
      upto(63);
      pins(1'h0, 1'h0);
      upto(64);
      pins(1'h1, 1'h0);
    end
    doReset();
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h07);
    upto(70);
    rd(wit_pkg::OFS_FLAG, 8'h00);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h0f);
    upto(40);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h1f);
    upto(63);
    rd(wit_pkg::OFS_FLAG, 8'h00);
    upto(64);
    rd(wit_pkg::OFS_FLAG, 8'h01);
    pins(1'h0, 1'h0);
    wr(wit_pkg::OFS_IRQEN, 8'h01);
    repeat (3) @(negedge clock);
    pins(1'h0, 1'h1);
    wr(wit_pkg::OFS_FLAG, 8'h01);
    repeat (3) @(negedge clock);
    pins(1'h0, 1'h0);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h07);
    upto(70);
    pins(1'h0, 1'h0);
    mark();
    wr(wit_pkg::OFS_CONTROL, 8'h0f);
    upto(63);
    pins(1'h0, 1'h0);
    upto(64);
    pins(1'h0, 1'h1);
    wr(wit_pkg::OFS_FLAG, 8'h01);
    halfPer = 3;
    for (int k = 0; k < 3; k++) begin
      mark();
      wr(wit_pkg::OFS_CONTROL, {6'h03, codes[k]});
      upto(pers[k] - 1);
      pins(1'h0, 1'h0);
      upto(pers[k]);
      pins(1'h0, 1'h1);
      wr(wit_pkg::OFS_FLAG, 8'h01);
    end
    end_of_test();
  end
endmodule // wit_guard_tb

bind wit_guard wit_guard_assertions u_wit_guard_assertions (.clock(clock), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sysResetReq(sysResetReq), .guardIrqReq(guardIrqReq));
